//--- core/acmpc_ctrl.sv
// analog comparator control, event detection and register file
//
// Function
// R1 - result bit is one when plus exceeds minus
// R2 - invert control flips result before status, events
// R3 - event flag set only when enabled, matching edge
// R4 - event flag sticky until software writes zero
// R5 - mode 01 falling, 10 rising, 11 either
// R6 - disabled comparator: output low, no events
// R7 - keep-alive bit keeps comparator running in powerdown
// R8 - powerdown wake only on sustained output level
// R9 - low-power bit selects comparator low-power mode
// R10 - interrupt request gated by extended enable bit
// R11 - negative select 0000 pin, 1111 reference
// R12 - filter 00 off, 01 three clocks, 10 slow
// R13 - positive select routes one of four pins
// R14 - pin enable drives result onto port pin
// R15 - reference enable switches internal reference
// R16 - synchronise, filter, invert, then detect edges once
`timescale 1ns/1ps
module acmpc_ctrl
    import acmpc_pkg::*;
(
    input wire logic clk, // system clock, 100 MHz
    input wire logic rst_b, // asynchronous reset, active low
    input wire logic [7:0] sfr_addr, // register address
    input wire logic [7:0] sfr_wdata, // write data
    input wire logic sfr_wr, // write strobe, one cycle
    input wire logic sfr_rd, // read strobe, one cycle
    output logic [7:0] sfr_rdata, // read data, valid cycle after sfr_rd
    input wire logic powerdown_state, // processor is in powerdown
    input wire logic cmp_raw, // analog comparator core output
    output logic [1:0] pos_input_select, // plus input mux select
    output logic [3:0] neg_input_select, // minus input mux select
    output logic cmp_analog_on, // comparator core powered
    output logic cmp_low_power, // comparator core low-power mode
    output logic int_reference_enable, // internal reference on
    output logic cmp_pin_out, // port pin output value
    output logic cmp_pin_oe_b, // port pin output enable, low drives
    output logic cmp_irq, // interrupt request, level
    output logic cmp_wake // powerdown wake request, level
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [7:0] power_control_three;
        logic [7:0] ctl;
        logic [7:0] imode;
        logic [7:0] aux4;
        logic [7:0] eie;
        logic [7:0] rdata;
        logic sync1;
        logic sync2;
        logic [2:0] taps;
        logic filt;
        logic out_prev;
        logic [2:0] div;
        logic [1:0] pos_sel;
        logic [3:0] neg_sel;
        logic analog_on;
        logic low_power;
        logic ref_en;
        logic pin_out;
        logic pin_oe_b;
        logic irq;
        logic wake;
    } acmpc_state_type;

    acmpc_state_type st_reg;
    acmpc_state_type st_next;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_addr);
        hit = (a == ref_addr);
    endfunction

    logic en;
    logic cmp_out;
    logic rise;
    logic fall;
    logic evt;
    logic [1:0] flt_sel;
    logic tick;
    logic [7:0] status_view;

    always_comb begin
        st_next = st_reg;
        en = st_reg.ctl[BIT_ENABLE];
        flt_sel = {st_reg.aux4[BIT_FILTER_HIGH], st_reg.imode[BIT_FILTER_LOW]};
        // ****************************************
        // synchroniser; first stage feeds only the second
        // ****************************************
        st_next.sync1 = cmp_raw; // R16
        st_next.sync2 = st_reg.sync1; // R16
        // ****************************************
        // glitch filter: with filter on, output changes after three equal samples; off passes sync2 straight through
        // ****************************************
        st_next.div = (st_reg.div == SLOW_DIV_LAST) ? 3'h0 : st_reg.div + 3'h1;
        tick = (flt_sel == ACMPC_FLT_SLOW) ? (st_reg.div == SLOW_DIV_LAST) : 1'b1; // R12
        if (tick) begin
            st_next.taps = {st_reg.taps[1:0], st_reg.sync2};
        end
        case (flt_sel)
            ACMPC_FLT_OFF: st_next.filt = st_reg.sync2; // R12
            ACMPC_FLT_FAST,
            ACMPC_FLT_SLOW: begin
                // reserved code 11 holds the last value rather than guessing
                if (st_reg.taps == 3'b111) begin
                    st_next.filt = 1'b1; // R12
                end else if (st_reg.taps == 3'b000) begin
                    st_next.filt = 1'b0; // R12
                end
            end
            default: st_next.filt = st_reg.filt;
        endcase
        // ****************************************
        // invert and enable gating, then edge detect
        // ****************************************
        cmp_out = en & (st_reg.filt ^ st_reg.ctl[BIT_INVERT]); // R1 R2 R6
        st_next.out_prev = cmp_out; // R16
        rise = cmp_out & ~st_reg.out_prev;
        fall = ~cmp_out & st_reg.out_prev;
        case (acmpc_mode_type'(st_reg.ctl[BIT_MODE_HI:BIT_MODE_LO]))
            ACMPC_MODE_FALL: evt = fall; // R5
            ACMPC_MODE_RISE: evt = rise; // R5
            ACMPC_MODE_TOGGLE: evt = rise | fall; // R5
            default: evt = 1'b0;
        endcase
        // an edge caused by toggling enable itself is not counted
        evt = evt & en & st_reg.analog_on & ~powerdown_state; // R3 R6
        status_view = st_reg.ctl;
        status_view[BIT_RESULT] = cmp_out; // R1
        // ****************************************
        // register writes
        // ****************************************
        if (sfr_wr) begin
            if (hit(sfr_addr, ADDR_POWER_CONTROL_THREE)) begin
                st_next.power_control_three = sfr_wdata & WMASK_POWER_CONTROL_THREE;
            end
            if (hit(sfr_addr, ADDR_CMP_CONTROL_STATUS)) begin
                st_next.ctl = sfr_wdata;
                st_next.ctl[BIT_RESULT] = 1'b0;
                // a one written keeps the flag; only zero clears
                st_next.ctl[BIT_EVENT_FLAG] = st_reg.ctl[BIT_EVENT_FLAG]
                    & sfr_wdata[BIT_EVENT_FLAG]; // R4
            end
            if (hit(sfr_addr, ADDR_CMP_INPUT_MODE)) begin
                st_next.imode = sfr_wdata & WMASK_CMP_INPUT_MODE;
            end
            if (hit(sfr_addr, ADDR_AUXILIARY_FOUR)) begin
                st_next.aux4 = sfr_wdata & WMASK_AUXILIARY_FOUR;
            end
            if (hit(sfr_addr, ADDR_EXT_IRQ_ENABLE)) begin
                st_next.eie = sfr_wdata & WMASK_EXT_IRQ_ENABLE;
            end
        end
        // set wins over a clearing write in the same cycle
        if (evt) begin
            st_next.ctl[BIT_EVENT_FLAG] = 1'b1; // R3 R4
        end
        // ****************************************
        // register reads
        // ****************************************
        if (sfr_rd) begin
            if (hit(sfr_addr, ADDR_POWER_CONTROL_THREE)) begin
                st_next.rdata = st_reg.power_control_three;
            end else if (hit(sfr_addr, ADDR_CMP_CONTROL_STATUS)) begin
                st_next.rdata = status_view;
            end else if (hit(sfr_addr, ADDR_CMP_INPUT_MODE)) begin
                st_next.rdata = st_reg.imode;
            end else if (hit(sfr_addr, ADDR_AUXILIARY_FOUR)) begin
                st_next.rdata = st_reg.aux4;
            end else if (hit(sfr_addr, ADDR_EXT_IRQ_ENABLE)) begin
                st_next.rdata = st_reg.eie;
            end else begin
                st_next.rdata = 8'h00;
            end
        end
        // ****************************************
        // analog controls and outputs
        // ****************************************
        st_next.pos_sel = st_reg.imode[BIT_POS_SEL_HI:BIT_POS_SEL_LO]; // R13
        st_next.neg_sel = st_reg.imode[BIT_NEG_SEL_HI:BIT_NEG_SEL_LO]; // R11
        st_next.analog_on = en
            & (~powerdown_state | st_reg.ctl[BIT_PD_KEEPALIVE]); // R7
        st_next.low_power = st_reg.ctl[BIT_LOW_POWER]; // R9
        st_next.ref_en = st_reg.power_control_three[BIT_REF_ENABLE]; // R15
        st_next.pin_out = cmp_out; // R14
        st_next.pin_oe_b = ~st_reg.aux4[BIT_PIN_OE]; // R14
        st_next.irq = st_next.ctl[BIT_EVENT_FLAG] & st_reg.eie[BIT_CMP_IRQ_ENABLE]; // R10
        // in powerdown the edge logic is not trusted; wake on the
        // filtered level matching the selected mode instead
        st_next.wake = powerdown_state & en & st_reg.ctl[BIT_PD_KEEPALIVE]
            & st_reg.eie[BIT_CMP_IRQ_ENABLE]
            & (((st_reg.ctl[BIT_MODE_HI:BIT_MODE_LO] == ACMPC_MODE_RISE) & cmp_out)
            | ((st_reg.ctl[BIT_MODE_HI:BIT_MODE_LO] == ACMPC_MODE_FALL) & ~cmp_out)
            | ((st_reg.ctl[BIT_MODE_HI:BIT_MODE_LO] == ACMPC_MODE_TOGGLE)
            & (cmp_out == st_reg.out_prev))); // R8
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
            st_reg.power_control_three <= RST_POWER_CONTROL_THREE;
            st_reg.ctl <= RST_CMP_CONTROL_STATUS;
            st_reg.imode <= RST_CMP_INPUT_MODE;
            st_reg.aux4 <= RST_AUXILIARY_FOUR;
            st_reg.eie <= RST_EXT_IRQ_ENABLE;
            st_reg.pin_oe_b <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sfr_rdata = st_reg.rdata;
    assign pos_input_select = st_reg.pos_sel;
    assign neg_input_select = st_reg.neg_sel;
    assign cmp_analog_on = st_reg.analog_on;
    assign cmp_low_power = st_reg.low_power;
    assign int_reference_enable = st_reg.ref_en;
    assign cmp_pin_out = st_reg.pin_out;
    assign cmp_pin_oe_b = st_reg.pin_oe_b;
    assign cmp_irq = st_reg.irq;
    assign cmp_wake = st_reg.wake;

endmodule

//--- core/acmpc_pkg.sv
// package for the analog comparator control block
package acmpc_pkg;
    // ****************************************
    // register addresses
    // ****************************************
    localparam logic [7:0] ADDR_POWER_CONTROL_THREE = 8'h45;
    localparam logic [7:0] ADDR_CMP_CONTROL_STATUS = 8'h9e;
    localparam logic [7:0] ADDR_CMP_INPUT_MODE = 8'h9f;
    localparam logic [7:0] ADDR_AUXILIARY_FOUR = 8'ha4;
    localparam logic [7:0] ADDR_EXT_IRQ_ENABLE = 8'he6;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] RST_POWER_CONTROL_THREE = 8'h00;
    localparam logic [7:0] RST_CMP_CONTROL_STATUS = 8'h00;
    localparam logic [7:0] RST_CMP_INPUT_MODE = 8'h00;
    localparam logic [7:0] RST_AUXILIARY_FOUR = 8'h00;
    localparam logic [7:0] RST_EXT_IRQ_ENABLE = 8'h00;
    // ****************************************
    // field positions
    // ****************************************
    localparam int BIT_LOW_POWER = 7;
    localparam int BIT_PD_KEEPALIVE = 6;
    localparam int BIT_RESULT = 5;
    localparam int BIT_EVENT_FLAG = 4;
    localparam int BIT_ENABLE = 3;
    localparam int BIT_INVERT = 2;
    localparam int BIT_MODE_HI = 1;
    localparam int BIT_MODE_LO = 0;
    localparam int BIT_NEG_SEL_HI = 7;
    localparam int BIT_NEG_SEL_LO = 4;
    localparam int BIT_FILTER_LOW = 2;
    localparam int BIT_POS_SEL_HI = 1;
    localparam int BIT_POS_SEL_LO = 0;
    localparam int BIT_PIN_OE = 1;
    localparam int BIT_FILTER_HIGH = 0;
    localparam int BIT_REF_ENABLE = 7;
    localparam int BIT_CMP_IRQ_ENABLE = 7;
    // writable masks; reserved bits read zero
    localparam logic [7:0] WMASK_POWER_CONTROL_THREE = 8'h80;
    localparam logic [7:0] WMASK_CMP_INPUT_MODE = 8'hf7;
    localparam logic [7:0] WMASK_AUXILIARY_FOUR = 8'h03;
    localparam logic [7:0] WMASK_EXT_IRQ_ENABLE = 8'h80;
    // ****************************************
    // timing
    // ****************************************
    localparam int FILTER_TAPS = 3;
    localparam int SLOW_DIVIDE = 6;
    localparam logic [2:0] SLOW_DIV_LAST = 3'h5;
    // ****************************************
    // codes
    // ****************************************
    typedef enum logic [1:0] {
        ACMPC_MODE_RSVD = 2'b00,
        ACMPC_MODE_FALL = 2'b01,
        ACMPC_MODE_RISE = 2'b10,
        ACMPC_MODE_TOGGLE = 2'b11
    } acmpc_mode_type;
    typedef enum logic [1:0] {
        ACMPC_FLT_OFF = 2'b00,
        ACMPC_FLT_FAST = 2'b01,
        ACMPC_FLT_SLOW = 2'b10,
        ACMPC_FLT_RSVD = 2'b11
    } acmpc_filter_type;
    localparam logic [3:0] NEG_SEL_PIN = 4'h0;
    localparam logic [3:0] NEG_SEL_REF = 4'hf;
endpackage

//--- bench/acmpc_core_model.sv
// behavioural model of the analog comparator core and its reference
`timescale 1ns/1ps
module acmpc_core_model #(
    parameter int NEG_MV = 1000
) (
    input wire logic [1:0] pos_input_select, // plus mux select
    input wire logic [3:0] neg_input_select, // minus mux select
    input wire logic cmp_analog_on, // core powered
    input wire logic int_reference_enable, // reference on
    input int pin_mv [4], // plus pin levels in mV
    output logic cmp_raw // plus above minus
);
    int minus_mv;
    always_comb begin
        minus_mv = NEG_MV;
        if (neg_input_select == 4'hf) begin
            // a switched-off reference reads as ground
            minus_mv = int_reference_enable ? 1400 : 0;
        end
        // a gated-off core cannot hold its last answer
        cmp_raw = cmp_analog_on && (pin_mv[pos_input_select] > minus_mv);
    end
endmodule

//--- bench/acmpc_ctrl_assertions.sv
// concurrent checks on the comparator control ports
`timescale 1ns/1ps
module acmpc_ctrl_assertions
    import acmpc_pkg::*;
(
    input wire logic clk, // clock
    input wire logic rst_b, // reset
    input wire logic [7:0] sfr_addr, // address
    input wire logic [7:0] sfr_wdata, // write data
    input wire logic sfr_wr, // write strobe
    input wire logic powerdown_state, // powerdown
    input wire logic [1:0] pos_input_select, // plus select
    input wire logic [3:0] neg_input_select, // minus select
    input wire logic cmp_low_power, // low power
    input wire logic int_reference_enable, // reference on
    input wire logic cmp_pin_out, // pin value
    input wire logic cmp_pin_oe_b, // pin enable
    input wire logic cmp_irq, // interrupt
    input wire logic cmp_wake // wake
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [7:0] wd1;
    logic [7:0] wd2;
    // write data two edges back, to match the output latency
    always_ff @(posedge clk) begin
        wd1 <= sfr_wdata;
        wd2 <= wd1;
    end
    property p_sel;
        sfr_wr && sfr_addr == ADDR_CMP_INPUT_MODE |->
            ##2 pos_input_select == wd2[1:0] && neg_input_select == wd2[7:4];
    endproperty
    a_sel: assert property (p_sel) else $error("input selects wrong");
    property p_ref;
        sfr_wr && sfr_addr == ADDR_POWER_CONTROL_THREE |-> ##2 int_reference_enable == wd2[7];
    endproperty
    a_ref: assert property (p_ref) else $error("reference enable wrong");
    property p_lp;
        sfr_wr && sfr_addr == ADDR_CMP_CONTROL_STATUS |-> ##2 cmp_low_power == wd2[7];
    endproperty
    a_lp: assert property (p_lp) else $error("low power wrong");
    property p_oe;
        sfr_wr && sfr_addr == ADDR_AUXILIARY_FOUR |-> ##2 cmp_pin_oe_b == !wd2[1];
    endproperty
    a_oe: assert property (p_oe) else $error("pin enable wrong");
    property p_off;
        sfr_wr && sfr_addr == ADDR_CMP_CONTROL_STATUS && !sfr_wdata[3] |-> ##[2:3] !cmp_pin_out;
    endproperty
    a_off: assert property (p_off) else $error("disabled output not low");
    property p_irq_en;
        sfr_wr && sfr_addr == ADDR_EXT_IRQ_ENABLE && !sfr_wdata[7] |-> ##2 !cmp_irq;
    endproperty
    a_irq_en: assert property (p_irq_en) else $error("masked interrupt raised");
    property p_sticky;
        cmp_irq && !sfr_wr && !$past(sfr_wr) |=> cmp_irq;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped by itself");
    property p_wake;
        !powerdown_state && !$past(powerdown_state) |-> !cmp_wake;
    endproperty
    a_wake: assert property (p_wake) else $error("wake outside powerdown");
    c_irq: cover property ($rose(cmp_irq));
    c_wake: cover property ($rose(cmp_wake));
    c_pin: cover property (!cmp_pin_oe_b && $rose(cmp_pin_out));
endmodule
bind acmpc_ctrl acmpc_ctrl_assertions acmpc_ctrl_assertions_i (.clk(clk), .rst_b(rst_b),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .powerdown_state(powerdown_state),
    .pos_input_select(pos_input_select), .neg_input_select(neg_input_select),
    .cmp_low_power(cmp_low_power), .int_reference_enable(int_reference_enable),
    .cmp_pin_out(cmp_pin_out), .cmp_pin_oe_b(cmp_pin_oe_b), .cmp_irq(cmp_irq), .cmp_wake(cmp_wake));

//--- bench/test_analog_comparator_ctrl.sv
// self-checking bench for the comparator control block
`timescale 1ns/1ps
module test_analog_comparator_ctrl;
    import acmpc_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, powerdown_state = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, d;
    logic [1:0] pos_input_select;
    logic [3:0] neg_input_select;
    logic cmp_raw, cmp_analog_on, cmp_low_power, int_reference_enable;
    logic cmp_pin_out, cmp_pin_oe_b, cmp_irq, cmp_wake;
    logic [7:0] ra [6] = '{8'h45, 8'h9e, 8'h9f, 8'ha4, 8'he6, 8'h33};
    logic [7:0] rw [4] = '{8'h45, 8'h9f, 8'ha4, 8'he6};
    logic [7:0] rm [4] = '{8'h80, 8'hf7, 8'h03, 8'h80};
    logic [1:0] flt [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
    int len [5] = '{2, 2, 12, 6, 40};
    logic [4:0] fexp = 5'h15;
    int pin_mv [4] = '{default: 500};
    int n_fail = 0, num_checks = 0;
    acmpc_ctrl acmpc_ctrl_i (.clk(clk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .powerdown_state(powerdown_state),
        .cmp_raw(cmp_raw), .pos_input_select(pos_input_select), .neg_input_select(neg_input_select),
        .cmp_analog_on(cmp_analog_on), .cmp_low_power(cmp_low_power), .cmp_wake(cmp_wake),
        .int_reference_enable(int_reference_enable), .cmp_pin_out(cmp_pin_out),
        .cmp_pin_oe_b(cmp_pin_oe_b), .cmp_irq(cmp_irq));
    acmpc_core_model acmpc_core_model_i (.pos_input_select(pos_input_select),
        .neg_input_select(neg_input_select), .cmp_analog_on(cmp_analog_on),
        .int_reference_enable(int_reference_enable), .pin_mv(pin_mv), .cmp_raw(cmp_raw));
    // ***
    // helpers
    // ***
    function automatic logic ev(int m, logic o);
        return m == 3 || (m == 2 && o) || (m == 1 && !o);
    endfunction
    task automatic chk(logic [7:0] g, logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic hold(int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] v);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= v;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] m, logic [7:0] e);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1 chk(sfr_rdata & m, e);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ***
    // sequence
    // ***
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        #200us;
        n_fail++;
        stop_test;
    end
    initial begin
        void'($urandom(32'h4f83));
        hold(5);
        rst_b <= 1'b1;
        foreach (ra[i]) rd(ra[i], 8'hff, 8'h00);
        wr(8'h33, 8'hff);
        wr(ADDR_CMP_CONTROL_STATUS, 8'h10);
        rd(8'h33, 8'hff, 8'h00);
        rd(ADDR_CMP_CONTROL_STATUS, 8'hff, 8'h00);
        for (int i = 0; i < 16; i++) begin
            d = 8'($urandom);
            wr(rw[i % 4], d);
            rd(rw[i % 4], 8'hff, d & rm[i % 4]);
        end
        wr(ADDR_CMP_INPUT_MODE, 8'h00);
        wr(ADDR_AUXILIARY_FOUR, 8'h00);
        wr(ADDR_EXT_IRQ_ENABLE, 8'h80);
        // every mode, both polarities, both directions
        for (int k = 0; k < 16; k++) begin
            d = {5'h01, k[2], k[1:0] ^ 2'(k >> 2)};
            pin_mv[0] <= k[3] ? 500 : 2000;
            wr(ADDR_CMP_CONTROL_STATUS, d);
            hold(10);
            wr(ADDR_CMP_CONTROL_STATUS, d);
            pin_mv[0] <= k[3] ? 2000 : 500;
            hold(10);
            rd(ADDR_CMP_CONTROL_STATUS, 8'h30, {2'h0, k[3] ^ k[2], ev(d[1:0], k[3] ^ k[2]), 4'h0});
            chk({7'h0, cmp_irq}, {7'h0, ev(d[1:0], k[3] ^ k[2])});
        end
        // disabled: input swings but nothing shows
        wr(ADDR_CMP_CONTROL_STATUS, 8'h07);
        pin_mv[0] <= 500;
        hold(10);
        pin_mv[0] <= 2000;
        hold(10);
        rd(ADDR_CMP_CONTROL_STATUS, 8'h30, 8'h00);
        pin_mv[0] <= 500;
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_CMP_INPUT_MODE, {5'h00, flt[i][0], 2'h0});
            wr(ADDR_AUXILIARY_FOUR, {7'h00, flt[i][1]});
            hold(40);
            wr(ADDR_CMP_CONTROL_STATUS, 8'h0b);
            pin_mv[0] <= 2000;
            hold(len[i]);
            pin_mv[0] <= 500;
            hold(60);
            rd(ADDR_CMP_CONTROL_STATUS, 8'h10, {3'h0, fexp[i], 4'h0});
        end
        wr(ADDR_AUXILIARY_FOUR, 8'h02);
        wr(ADDR_CMP_CONTROL_STATUS, 8'h08);
        for (int s = 0; s < 4; s++) begin
            foreach (pin_mv[j]) pin_mv[j] <= (j == s) ? 2000 : 500;
            wr(ADDR_CMP_INPUT_MODE, {6'h00, 2'(s)});
            hold(8);
            rd(ADDR_CMP_CONTROL_STATUS, 8'h20, 8'h20);
            chk({6'h0, cmp_pin_oe_b, cmp_pin_out}, 8'h01);
        end
        pin_mv[3] <= 1200;
        wr(ADDR_POWER_CONTROL_THREE, 8'h80);
        wr(ADDR_CMP_INPUT_MODE, 8'hf3);
        hold(8);
        rd(ADDR_CMP_CONTROL_STATUS, 8'h20, 8'h00);
        pin_mv[3] <= 2000;
        wr(ADDR_CMP_CONTROL_STATUS, 8'hca);
        powerdown_state <= 1'b1;
        hold(20);
        chk({5'h0, cmp_wake, cmp_analog_on, cmp_low_power}, 8'h07);
        wr(ADDR_CMP_CONTROL_STATUS, 8'h0a);
        hold(5);
        chk({6'h0, cmp_analog_on, cmp_low_power}, 8'h00);
        powerdown_state <= 1'b0;
        hold(5);
        stop_test;
    end
endmodule
